// ---- logic/sbx_exec.sv ----
// Functional notes
// [RQ1] Ten-bit literal form: register minus literal minus borrow, back into register.
// [RQ2] Software keeps literal within 0..255 for byte, 0..1023 for word.
// [RQ3] Width bit: 0 selects word, 1 selects byte, for all forms.
// [RQ4] Borrow into every subtraction is the inverse of carry.
// [RQ5] Zero flag only cleared: nonzero result clears, zero result leaves it.
// [RQ6] Short literal form: base minus literal minus borrow into destination.
// [RQ7] Register form: base minus source minus borrow into destination, flags updated.
// [RQ8] Base is register direct; source and destination allow indirect with pointer updates.
// [RQ9] Fields: w base, q destination mode, d destination, p source mode, s source.
// [RQ10] File form: default register minus memory operand minus borrow.
// [RQ11] File form destination bit: 0 default register, 1 memory location.
// [RQ12] Default register is working register zero.
// [RQ13] Reversed short form: literal minus base minus borrow into destination.
// [RQ14] Short literal is unsigned five bits, zero-extended.
// [RQ15] Ten-bit literal target is always a register accessed directly.
// [RQ16] Byte operation writes low byte of a register, keeps upper byte.
// [RQ17] Carry, nibble carry are no-borrow; sign is top bit; overflow two's complement.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module sbx_exec (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [15:0] mem_wdata,
   output logic [1:0] mem_be,
   input wire logic [15:0] mem_rdata
);

   typedef enum logic [1:0] {S_IDLE, S_ADDR, S_WAIT, S_EXEC} sbx_state_type;

   typedef struct packed {
      sbx_state_type state;
      logic [15:0][15:0] default_accum_register;
      logic [23:0] instr;
      logic src_mem;
      logic c;
      logic z;
      logic ov;
      logic n;
      logic dc;
      logic err;
      logic ok;
      logic [31:0] prdata;
      logic [15:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [15:0] mem_wdata;
      logic [1:0] mem_be;
      logic [15:0] mem_data;
   } sbx_core_type;

   sbx_core_type core_reg;
   sbx_core_type core_next;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] eff_addr(input logic [2:0] mode, input logic [15:0] ptr,
                                            input logic [15:0] step);
      unique case (mode)
         sbx_pkg::MODE_PRE_DEC: eff_addr = ptr - step;
         sbx_pkg::MODE_PRE_INC: eff_addr = ptr + step;
         default: eff_addr = ptr;
      endcase
   endfunction

   function automatic logic [15:0] ptr_update(input logic [2:0] mode, input logic [15:0] ptr,
                                              input logic [15:0] step);
      unique case (mode)
         sbx_pkg::MODE_POST_DEC, sbx_pkg::MODE_PRE_DEC: ptr_update = ptr - step;
         sbx_pkg::MODE_POST_INC, sbx_pkg::MODE_PRE_INC: ptr_update = ptr + step;
         default: ptr_update = ptr;
      endcase
   endfunction

   function automatic logic mode_ok(input logic [2:0] mode);
      mode_ok = (mode <= sbx_pkg::MODE_PRE_INC);
   endfunction

   function automatic logic [15:0] merge(input logic byte_mode, input logic [15:0] old,
                                         input logic [15:0] res);
      merge = byte_mode ? {old[15:8], res[7:0]} : res; // [RQ16]
   endfunction

   // ----------------------------------------
   // Instruction field decode
   // ----------------------------------------
   logic [23:0] ins;
   logic is_ten_bit_literal;
   logic is_file;
   logic is_short;
   logic is_fwd;
   logic is_rev;
   logic byte_mode;
   logic [3:0] w_idx;
   logic [2:0] q_mode;
   logic [3:0] d_idx;
   logic [2:0] p_mode;
   logic [3:0] s_idx;
   logic [15:0] five_bit_literal;
   logic [15:0] ten_bit_literal;
   logic [3:0] literal_target_reg;
   logic file_dest_mem;
   logic [15:0] file_addr;
   logic [15:0] step;

   assign ins = core_reg.instr;
   assign is_ten_bit_literal = (ins[23:15] == sbx_pkg::TEN_BIT_LITERAL_OP);
   assign is_file = (ins[23:15] == sbx_pkg::FILE_REV_OP);
   assign is_short = (ins[6:5] == sbx_pkg::SHORT_LIT_TAG);
   assign is_fwd = (ins[23:19] == sbx_pkg::SHORT_FWD_OP);
   assign is_rev = (ins[23:19] == sbx_pkg::SHORT_REV_OP);
   assign byte_mode = ins[14]; // [RQ3]
   assign w_idx = ins[18:15]; // [RQ9]
   assign q_mode = ins[13:11]; // [RQ9]
   assign d_idx = ins[10:7]; // [RQ9]
   assign p_mode = ins[6:4]; // [RQ9]
   assign s_idx = ins[3:0]; // [RQ9]
   assign five_bit_literal = {11'h000, ins[4:0]}; // [RQ14]
   assign ten_bit_literal = {6'h00, ins[13:4]};
   assign literal_target_reg = ins[3:0];
   assign file_dest_mem = ins[13];
   assign file_addr = {3'h0, ins[12:0]};
   assign step = byte_mode ? sbx_pkg::BYTE_STEP : sbx_pkg::WORD_STEP;

   // Legality check on a freshly written word
   function automatic logic legal(input logic [23:0] x);
      logic short_tag;
      short_tag = (x[6:5] == sbx_pkg::SHORT_LIT_TAG);
      if (x[23:15] == sbx_pkg::TEN_BIT_LITERAL_OP || x[23:15] == sbx_pkg::FILE_REV_OP) begin
         legal = 1'b1;
      end else if (x[23:19] == sbx_pkg::SHORT_FWD_OP) begin
         legal = mode_ok(x[13:11]) && (short_tag || mode_ok(x[6:4]));
      end else if (x[23:19] == sbx_pkg::SHORT_REV_OP) begin
         // Reversed register-register variant is not handled by this unit
         legal = short_tag && mode_ok(x[13:11]);
      end else begin
         legal = 1'b0;
      end
   endfunction

   // ----------------------------------------
   // Operand selection
   // ----------------------------------------
   logic [15:0] mem_operand;
   logic [15:0] op_a;
   logic [15:0] op_b;
   logic [15:0] sub_result;
   logic sub_c;
   logic sub_dc;
   logic sub_n;
   logic sub_ov;
   logic sub_nz;

   always_comb begin
      if (byte_mode) begin
         mem_operand = {8'h00, core_reg.mem_addr[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
      end else begin
         mem_operand = mem_rdata;
      end
      if (is_ten_bit_literal) begin
         op_a = core_reg.default_accum_register[literal_target_reg]; // [RQ1] [RQ15]
         op_b = ten_bit_literal;
      end else if (is_file) begin
         op_a = core_reg.default_accum_register[sbx_pkg::DEFAULT_ACCUM_IDX]; // [RQ10] [RQ12]
         op_b = core_reg.mem_data;
      end else if (is_rev) begin
         op_a = five_bit_literal; // [RQ13]
         op_b = core_reg.default_accum_register[w_idx];
      end else if (is_short) begin
         op_a = core_reg.default_accum_register[w_idx]; // [RQ6] [RQ8]
         op_b = five_bit_literal;
      end else begin
         op_a = core_reg.default_accum_register[w_idx]; // [RQ7]
         op_b = core_reg.src_mem ? core_reg.mem_data : core_reg.default_accum_register[s_idx];
      end
   end

   sbx_sub_unit u_sub (
      .byte_mode(byte_mode),
      .minuend(op_a),
      .subtrahend(op_b),
      .carry_in(core_reg.c),
      .result(sub_result),
      .carry_out(sub_c),
      .nibble_carry_flag(sub_dc),
      .negative(sub_n),
      .arith_range_exceeded_flag(sub_ov),
      .nonzero(sub_nz)
   );

   // ----------------------------------------
   // Register bus decode
   // ----------------------------------------
   logic in_default_accum_register;
   logic mapped;
   logic [31:0] status_word;

   assign in_default_accum_register = (paddr[11:6] == sbx_pkg::DEFAULT_ACCUM_REGISTER_BASE[11:6]) && (paddr[1:0] == 2'h0);
   assign mapped = in_default_accum_register || paddr == sbx_pkg::INSTR_OFFSET || paddr == sbx_pkg::STATUS_OFFSET;
   // Reads are staged one cycle ahead so read data comes from a flop
   assign pready = psel && penable && core_reg.ok;
   assign pslverr = pready && !mapped;

   always_comb begin
      status_word = sbx_pkg::STATUS_RESET;
      status_word[sbx_pkg::C_BIT] = core_reg.c;
      status_word[sbx_pkg::Z_BIT] = core_reg.z;
      status_word[sbx_pkg::OV_BIT] = core_reg.ov;
      status_word[sbx_pkg::N_BIT] = core_reg.n;
      status_word[sbx_pkg::DC_BIT] = core_reg.dc;
      status_word[sbx_pkg::BUSY_BIT] = (core_reg.state != S_IDLE);
      status_word[sbx_pkg::ERR_BIT] = core_reg.err;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [15:0] dst_addr;

   always_comb begin
      core_next = core_reg;
      core_next.mem_rd = 1'b0;
      core_next.mem_wr = 1'b0;
      dst_addr = eff_addr(q_mode, core_reg.default_accum_register[d_idx], step);
      core_next.ok = psel && (core_reg.state == S_IDLE) && !(penable && core_reg.ok);
      if (psel && core_reg.state == S_IDLE) begin
         if (in_default_accum_register) begin
            core_next.prdata = {16'h0000, core_reg.default_accum_register[paddr[5:2]]};
         end else if (paddr == sbx_pkg::INSTR_OFFSET) begin
            core_next.prdata = {8'h00, core_reg.instr};
         end else if (paddr == sbx_pkg::STATUS_OFFSET) begin
            core_next.prdata = status_word;
         end else begin
            core_next.prdata = 32'h0000_0000;
         end
      end
      unique case (core_reg.state)
         S_IDLE: begin
            if (pready && pwrite) begin
               if (in_default_accum_register) begin
                  core_next.default_accum_register[paddr[5:2]] = pwdata[15:0];
               end else if (paddr == sbx_pkg::INSTR_OFFSET) begin
                  core_next.instr = pwdata[23:0];
                  if (legal(pwdata[23:0])) begin
                     core_next.state = S_ADDR;
                  end else begin
                     core_next.err = 1'b1;
                  end
               end else if (paddr == sbx_pkg::STATUS_OFFSET) begin
                  core_next.c = pwdata[sbx_pkg::C_BIT];
                  core_next.z = pwdata[sbx_pkg::Z_BIT];
                  core_next.ov = pwdata[sbx_pkg::OV_BIT];
                  core_next.n = pwdata[sbx_pkg::N_BIT];
                  core_next.dc = pwdata[sbx_pkg::DC_BIT];
                  // Error flag clears on write of one
                  if (pwdata[sbx_pkg::ERR_BIT]) begin
                     core_next.err = 1'b0;
                  end
               end
            end
         end
         S_ADDR: begin
            core_next.src_mem = 1'b0;
            core_next.state = S_EXEC;
            if (is_file) begin
               core_next.src_mem = 1'b1;
               core_next.mem_addr = file_addr; // [RQ10]
               core_next.mem_rd = 1'b1;
               core_next.state = S_WAIT;
            end else if (is_fwd && !is_short && p_mode != sbx_pkg::MODE_DIRECT) begin
               core_next.src_mem = 1'b1;
               core_next.mem_addr = eff_addr(p_mode, core_reg.default_accum_register[s_idx], step); // [RQ8]
               core_next.default_accum_register[s_idx] = ptr_update(p_mode, core_reg.default_accum_register[s_idx], step); // [RQ8]
               core_next.mem_rd = 1'b1;
               core_next.state = S_WAIT;
            end
         end
         S_WAIT: begin
            // Read data stands only while the strobe is up, so hold it here
            core_next.mem_data = mem_operand;
            core_next.state = S_EXEC;
         end
         S_EXEC: begin
            core_next.c = sub_c; // [RQ17]
            core_next.dc = sub_dc;
            core_next.n = sub_n;
            core_next.ov = sub_ov;
            // Sticky zero keeps multi-word chains correct
            if (sub_nz) begin
               core_next.z = 1'b0; // [RQ5]
            end
            if (is_ten_bit_literal) begin
               core_next.default_accum_register[literal_target_reg] = merge(byte_mode, op_a, sub_result); // [RQ1]
            end else if (is_file && !file_dest_mem) begin // [RQ11]
               core_next.default_accum_register[sbx_pkg::DEFAULT_ACCUM_IDX] = merge(byte_mode, op_a, sub_result);
            end else if (is_file || q_mode != sbx_pkg::MODE_DIRECT) begin
               core_next.mem_wr = 1'b1; // [RQ8] [RQ11]
               core_next.mem_addr = is_file ? file_addr : dst_addr;
               core_next.mem_wdata = byte_mode ? {2{sub_result[7:0]}} : sub_result;
               core_next.mem_be = !byte_mode ? 2'h3 : (core_next.mem_addr[0] ? 2'h2 : 2'h1);
               if (!is_file) begin
                  core_next.default_accum_register[d_idx] = ptr_update(q_mode, core_reg.default_accum_register[d_idx], step);
               end
            end else begin
               core_next.default_accum_register[d_idx] = merge(byte_mode, core_reg.default_accum_register[d_idx], sub_result);
            end
            core_next.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   assign prdata = core_reg.prdata;
   assign mem_addr = core_reg.mem_addr;
   assign mem_rd = core_reg.mem_rd;
   assign mem_wr = core_reg.mem_wr;
   assign mem_wdata = core_reg.mem_wdata;
   assign mem_be = core_reg.mem_be;

endmodule

// ---- logic/sbx_pkg.sv ----
package sbx_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int unsigned DATA_W = 16;
   localparam int unsigned INSTR_W = 24;
   localparam int unsigned APB_ADDR_W = 12;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] INSTR_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] DEFAULT_ACCUM_REGISTER_BASE = 12'h040;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [23:0] INSTR_RESET = 24'h00_0000;

   // ----------------------------------------
   // Status bit positions
   // ----------------------------------------
   localparam int unsigned C_BIT = 0;
   localparam int unsigned Z_BIT = 1;
   localparam int unsigned OV_BIT = 2;
   localparam int unsigned N_BIT = 3;
   localparam int unsigned DC_BIT = 8;
   localparam int unsigned BUSY_BIT = 16;
   localparam int unsigned ERR_BIT = 17;

   // ----------------------------------------
   // Opcode prefixes and fields
   // ----------------------------------------
   localparam logic [8:0] TEN_BIT_LITERAL_OP = 9'h163;
   localparam logic [8:0] FILE_REV_OP = 9'h17b;
   localparam logic [4:0] SHORT_FWD_OP = 5'h0b;
   localparam logic [4:0] SHORT_REV_OP = 5'h03;
   localparam logic [1:0] SHORT_LIT_TAG = 2'h3;
   localparam logic [3:0] DEFAULT_ACCUM_IDX = 4'h0;

   // ----------------------------------------
   // Addressing mode codes (q and p fields)
   // ----------------------------------------
   localparam logic [2:0] MODE_DIRECT = 3'h0;
   localparam logic [2:0] MODE_INDIRECT = 3'h1;
   localparam logic [2:0] MODE_POST_DEC = 3'h2;
   localparam logic [2:0] MODE_POST_INC = 3'h3;
   localparam logic [2:0] MODE_PRE_DEC = 3'h4;
   localparam logic [2:0] MODE_PRE_INC = 3'h5;

   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] WORD_STEP = 16'h0002;

endpackage

// ---- logic/sbx_sub_unit.sv ----
`timescale 1ns/1ps

module sbx_sub_unit (
   input wire logic byte_mode,
   input wire logic [15:0] minuend,
   input wire logic [15:0] subtrahend,
   input wire logic carry_in,
   output logic [15:0] result,
   output logic carry_out,
   output logic nibble_carry_flag,
   output logic negative,
   output logic arith_range_exceeded_flag,
   output logic nonzero
);

   logic [16:0] word_sum;
   logic [8:0] byte_sum;
   logic [4:0] nib_sum;
   logic a_top;
   logic b_top;
   logic r_top;

   // ----------------------------------------
   // Add of inverted subtrahend plus carry
   // ----------------------------------------
   // Borrow in is the inverse of carry, so adding carry does it
   assign word_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {16'h0000, carry_in}; // [RQ4]
   assign byte_sum = {1'b0, minuend[7:0]} + {1'b0, ~subtrahend[7:0]} + {8'h00, carry_in};
   assign nib_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};

   assign result = byte_mode ? {8'h00, byte_sum[7:0]} : word_sum[15:0]; // [RQ16]
   assign carry_out = byte_mode ? byte_sum[8] : word_sum[16]; // [RQ17]
   assign nibble_carry_flag = nib_sum[4]; // [RQ17]
   assign a_top = byte_mode ? minuend[7] : minuend[15];
   assign b_top = byte_mode ? subtrahend[7] : subtrahend[15];
   assign r_top = byte_mode ? byte_sum[7] : word_sum[15];
   assign negative = r_top; // [RQ17]
   assign arith_range_exceeded_flag = (a_top ^ b_top) & (r_top ^ a_top); // [RQ17]
   assign nonzero = byte_mode ? (|byte_sum[7:0]) : (|word_sum[15:0]);

endmodule

// ---- verification/sbx_mem_model.sv ----
`timescale 1ns/1ps

module sbx_mem_model (
   input wire logic pclk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] mem_be,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:32767];
   logic tog = 1'b0;

   // Junk pattern while idle, so a stale sample never looks right
   assign mem_rdata = mem_rd ? mem[mem_addr[15:1]] : {8{tog, ~tog}};

   always @(posedge pclk) begin
      tog <= ~tog;
      if (mem_wr && mem_be[0]) begin
         mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
      end
      if (mem_wr && mem_be[1]) begin
         mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
      end
   end
endmodule

// ---- verification/sbx_exec_assertions.sv ----
`timescale 1ns/1ps

module sbx_exec_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] mem_be,
   input wire logic [15:0] mem_rdata
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_rd_wr_excl: assert property (!(mem_rd && mem_wr))
      else $error("memory read and write at once");
   chk_be_nonzero: assert property (mem_wr |-> mem_be != 2'b00)
      else $error("memory write with no lane enabled");
   chk_odd_lane: assert property (mem_wr && mem_addr[0] |-> mem_be == 2'b10)
      else $error("odd byte write not on upper lane");
   chk_low_lane_even: assert property (mem_wr && mem_be == 2'b01 |-> !mem_addr[0])
      else $error("lower lane write at odd address");
   chk_word_align: assert property (mem_wr && mem_be == 2'b11 |-> !mem_addr[0])
      else $error("word write at odd address");
   chk_ready_bound: assert property (psel && penable |-> ##[0:16] pready)
      else $error("bus access not answered in time");
   chk_ready_idle: assert property (!psel |-> !pready)
      else $error("ready without select");
   chk_err_access: assert property (pslverr |-> psel && penable && pready)
      else $error("error outside access phase");

   cov_mem_rd: cover property (mem_rd);
   cov_byte_wr: cover property (mem_wr && mem_be == 2'b10);
   cov_word_wr: cover property (mem_wr && mem_be == 2'b11);
   cov_err: cover property (pslverr);
endmodule

bind sbx_exec sbx_exec_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata));

// ---- verification/subtract_with_borrow_exec_tb.sv ----
`timescale 1ns/1ps

module subtract_with_borrow_exec_tb;
   typedef struct packed {
      logic [3:0] a;
      logic [15:0] va;
      logic [3:0] b;
      logic [15:0] vb;
      logic [15:0] sr;
      logic [23:0] ins;
      logic [3:0] d;
      logic [15:0] ev;
      logic [15:0] es;
   } sbx_row_type;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, mem_rd, mem_wr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic [15:0] mem_addr, mem_wdata, mem_rdata;
   logic [1:0] mem_be;
   logic errv;
   int num_errors = 0;
   int compares = 0;
   // Literals kept in range for the width: at most 8'hff in byte mode
   sbx_row_type rows [11] = '{
      '{4'h4,16'h6234,4'h4,16'h6234,16'h0001,24'hb19084,4'h4,16'h612c,16'h0001},
      '{4'h0,16'h7804,4'h0,16'h7804,16'h0000,24'hb1c230,4'h0,16'h78e0,16'h0108},
      '{4'h0,16'h0009,4'h1,16'h0000,16'h0002,24'h5800e8,4'h1,16'h0000,16'h0103},
      '{4'h0,16'h0009,4'h1,16'h1111,16'h0000,24'h5800e8,4'h1,16'h0000,16'h0101},
      '{4'h7,16'h2455,4'h8,16'h92e4,16'h0001,24'h5b8488,4'h9,16'h9171,16'h010c},
      '{4'h0,16'hf310,4'h1,16'h786a,16'h0003,24'h1840f0,4'h1,16'h7800,16'h0103},
      '{4'h0,16'h0009,4'h2,16'h0000,16'h0002,24'h180168,4'h2,16'hfffe,16'h0008},
      '{4'h3,16'h0000,4'h3,16'h0000,16'h0001,24'h5981ff,4'h3,16'hffe1,16'h0008},
      '{4'h0,16'h6234,4'h0,16'h6234,16'h0000,24'hbd8a04,4'h0,16'hfffe,16'h0008},
      '{4'h0,16'h7804,4'h0,16'h7804,16'h0001,24'hbde803,4'h0,16'h7804,16'h0100},
      '{4'h0,16'h0009,4'h2,16'h2004,16'h0001,24'h581968,4'h2,16'h2006,16'h0101}};

   always #25 pclk = ~pclk;

   sbx_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata));

   sbx_mem_model i_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata));

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask

   // Entered just after a rising edge; leaves one idle edge behind
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rdv = prdata;
      errv = pslverr;
      if (n >= 40) chk("pready", 32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [11:0] wadr(input logic [3:0] r);
      return sbx_pkg::DEFAULT_ACCUM_REGISTER_BASE + {6'h00, r, 2'b00};
   endfunction

   task automatic run(input sbx_row_type r);
      int n;
      n = 0;
      apb(1'b1, wadr(r.a), {16'h0, r.va});
      apb(1'b1, wadr(r.b), {16'h0, r.vb});
      apb(1'b1, sbx_pkg::STATUS_OFFSET, {16'h0, r.sr});
      apb(1'b1, sbx_pkg::INSTR_OFFSET, {8'h0, r.ins});
      rdv = 32'h0001_0000;
      while (rdv[sbx_pkg::BUSY_BIT] !== 1'b0 && n < 40) begin
         apb(1'b0, sbx_pkg::STATUS_OFFSET, 32'h0);
         n++;
      end
      chk("flags", {16'h0, r.es}, rdv & 32'h0000_010f);
      apb(1'b0, wadr(r.d), 32'h0);
      chk("dest", {16'h0, r.ev}, {16'h0, rdv[15:0]});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      i_mem.mem[16'h0502] = 16'h6235;
      i_mem.mem[16'h0401] = 16'h9400;
      i_mem.mem[16'h1002] = 16'ha557;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, sbx_pkg::STATUS_OFFSET, 32'h0);
      chk("status reset", sbx_pkg::STATUS_RESET, rdv);
      $display("reset test done");
      foreach (rows[i]) begin
         run(rows[i]);
         $display("row %0d done", i);
      end
      chk("byte to memory", 32'h7000, {16'h0, i_mem.mem[16'h0401]});
      chk("indirect store", 32'h0001, {16'h0, i_mem.mem[16'h1002]});
      $display("memory tests done");
      apb(1'b0, 12'h800, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, errv});
      $display("unmapped test done");
      stop_test();
   end

   initial begin
      #2000000;
      num_errors++;
      stop_test();
   end
endmodule
